// ---- rsu_pkg.sv ----
package rsu_pkg;
	localparam int RSU_ADDR_W = 8;
	localparam int RSU_DATA_W = 32;
	localparam int RSU_SR_W = 64;
	// register byte offsets
	localparam logic [7:0] RSU_CTRL_OFS = 8'h00;
	localparam logic [7:0] RSU_OPND_OFS = 8'h04;
	localparam logic [7:0] RSU_CNT_OFS = 8'h08;
	localparam logic [7:0] RSU_SRCFG_OFS = 8'h0c;
	localparam logic [7:0] RSU_RES_OFS = 8'h10;
	localparam logic [7:0] RSU_STAT_OFS = 8'h14;
	localparam logic [7:0] RSU_SRLO_OFS = 8'h18;
	localparam logic [7:0] RSU_SRHI_OFS = 8'h1c;
	// control word fields
	localparam int RSU_CTRL_OP_LSB = 0;
	localparam int RSU_CTRL_BADIND_BIT = 3;
	localparam int RSU_CTRL_DIN_BIT = 4;
	// shift register config fields: base bit [2:0], base byte [5:3], length [15:8]
	localparam int RSU_CFG_BASE_LSB = 0;
	localparam int RSU_CFG_LEN_LSB = 8;
	// status fields
	localparam int RSU_ST_ZF_BIT = 0;
	localparam int RSU_ST_OF_BIT = 1;
	localparam int RSU_ST_EN_OUT_BIT = 2;
	localparam int RSU_ST_MSBBIT_LSB = 4;
	localparam int RSU_ST_MSBBYTE_LSB = 8;
	localparam int RSU_ST_ERR_LSB = 16;
	// error codes
	localparam logic [15:0] RSU_ERR_NONE = 16'h0000;
	localparam logic [15:0] RSU_ERR_INDIRECT = 16'h0006;
	localparam logic [15:0] RSU_ERR_RANGE = 16'h0091;
	localparam logic [15:0] RSU_ERR_COUNT = 16'h0092;
	// operand size codes
	localparam logic [1:0] RSU_SZ_BYTE = 2'h0;
	localparam logic [1:0] RSU_SZ_WORD = 2'h1;
	localparam logic [1:0] RSU_SZ_DWORD = 2'h2;
	localparam logic [7:0] RSU_SR_MAX_LEN = 8'h40;
	// reset values
	localparam logic RSU_EN_OUT_RST = 1'b1;
	typedef enum logic [2:0] {
		RSU_OP_ROR_B = 3'h0,
		RSU_OP_ROR_W = 3'h1,
		RSU_OP_ROR_D = 3'h2,
		RSU_OP_ROL_B = 3'h3,
		RSU_OP_ROL_W = 3'h4,
		RSU_OP_ROL_D = 3'h5,
		RSU_OP_BIT_SR = 3'h6,
		RSU_OP_SWAP = 3'h7
	} rsu_op_t;
endpackage

// ---- rsu_rotator.sv ----
`timescale 1ns/1ns
module rsu_rotator
	import rsu_pkg::*;
(
	input wire logic [31:0] value,
	input wire logic [1:0] size,
	input wire logic left,
	input wire logic [7:0] count,
	output logic [31:0] result,
	output logic last_bit,
	output logic moved,
	output logic is_zero
);
	logic [31:0] rep;
	logic [31:0] mask;
	logic [4:0] eff;
	logic [63:0] dbl;
	logic [31:0] rot;
	logic [5:0] lshift;

	// replicate narrow operands so one 32-bit rotator serves every size
	always_comb begin
		unique case (size)
			RSU_SZ_BYTE: begin
				rep = {4{value[7:0]}};
				mask = 32'h000000ff;
				eff = {2'h0, count[2:0]};
			end
			RSU_SZ_WORD: begin
				rep = {2{value[15:0]}};
				mask = 32'h0000ffff;
				eff = {1'b0, count[3:0]};
			end
			default: begin
				rep = value;
				mask = 32'hffffffff;
				eff = count[4:0];
			end
		endcase
		dbl = {rep, rep};
		lshift = 6'h20 - {1'b0, eff};
		// circular shift; sign bit moves like any other bit
		rot = left ? dbl[lshift +: 32] : dbl[{1'b0, eff} +: 32];
		moved = (eff != 5'h00);
		result = moved ? (rot & mask) : (value & mask);
		// last bit moved lands in the top bit going right, in bit 0 going left
		unique case (size)
			RSU_SZ_BYTE: last_bit = left ? rot[0] : rot[7];
			RSU_SZ_WORD: last_bit = left ? rot[0] : rot[15];
			default: last_bit = left ? rot[0] : rot[31];
		endcase
		is_zero = ((value & mask) == 32'h00000000);
	end
endmodule

// ---- rsu_top.sv ----
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module rsu_top
	import rsu_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RSU_ADDR_W-1:0] paddr,
	input wire logic [RSU_DATA_W-1:0] pwdata,
	output logic [RSU_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic enable_out,
	output logic zero_flag,
	output logic overflow_flag
);
	// software-visible state
	logic [31:0] opnd_q, opnd_d;
	logic [7:0] cnt_q, cnt_d;
	logic [15:0] cfg_q, cfg_d;
	logic [31:0] res_q, res_d;
	logic [15:0] err_q, err_d;
	logic [4:0] msb_byte_q, msb_byte_d;
	logic [2:0] msb_bit_q, msb_bit_d;
	logic [RSU_SR_W-1:0] sr_q, sr_d;
	logic zf_q, zf_d;
	logic of_q, of_d;
	logic en_out_q, en_out_d;
	// bus answer
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;

	// decoded bus access
	logic wr_en;
	logic setup;
	logic issue;
	rsu_op_t op;
	logic bad_ind;
	logic din;
	// rotator hookup
	logic [1:0] rot_size;
	logic rot_left;
	logic [31:0] rot_res;
	logic rot_last;
	logic rot_moved;
	logic rot_zero;
	// bit register geometry and one step
	logic [5:0] base;
	logic [7:0] len;
	logic [7:0] mag;
	logic [7:0] top_idx;
	logic [RSU_SR_W-1:0] sr_shift;
	logic [RSU_SR_W-1:0] sr_up; // each bit holds its lower neighbour
	logic [RSU_SR_W-1:0] sr_dn; // each bit holds its upper neighbour
	logic sr_out;
	logic len_bad;
	logic range_bad;

	// address decode shared by write enable and error answer
	function automatic logic addr_mapped(input logic [RSU_ADDR_W-1:0] a);
		addr_mapped = (a == RSU_CTRL_OFS) || (a == RSU_OPND_OFS) || (a == RSU_CNT_OFS)
			|| (a == RSU_SRCFG_OFS) || (a == RSU_RES_OFS) || (a == RSU_STAT_OFS)
			|| (a == RSU_SRLO_OFS) || (a == RSU_SRHI_OFS);
	endfunction

	// writes land only on the access edge where pready is seen high
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && addr_mapped(paddr);
	assign issue = wr_en && (paddr == RSU_CTRL_OFS);
	assign op = rsu_op_t'(pwdata[RSU_CTRL_OP_LSB +: 3]);
	assign bad_ind = pwdata[RSU_CTRL_BADIND_BIT];
	assign din = pwdata[RSU_CTRL_DIN_BIT];

	// size and direction from the opcode
	always_comb begin
		rot_size = RSU_SZ_DWORD;
		rot_left = 1'b0;
		unique case (op)
			RSU_OP_ROR_B: rot_size = RSU_SZ_BYTE;
			RSU_OP_ROR_W: rot_size = RSU_SZ_WORD;
			RSU_OP_ROR_D: rot_size = RSU_SZ_DWORD;
			RSU_OP_ROL_B: begin
				rot_size = RSU_SZ_BYTE;
				rot_left = 1'b1;
			end
			RSU_OP_ROL_W: begin
				rot_size = RSU_SZ_WORD;
				rot_left = 1'b1;
			end
			RSU_OP_ROL_D: begin
				rot_size = RSU_SZ_DWORD;
				rot_left = 1'b1;
			end
			RSU_OP_BIT_SR: rot_size = RSU_SZ_DWORD;
			RSU_OP_SWAP: rot_size = RSU_SZ_WORD;
		endcase
	end

	rsu_rotator u_rot (
		.value(opnd_q),
		.size(rot_size),
		.left(rot_left),
		.count(cnt_q),
		.result(rot_res),
		.last_bit(rot_last),
		.moved(rot_moved),
		.is_zero(rot_zero)
	);

	// bit register geometry: base is byte*8+bit, length is signed
	always_comb begin
		base = cfg_q[RSU_CFG_BASE_LSB +: 6];
		len = cfg_q[RSU_CFG_LEN_LSB +: 8];
		mag = len[7] ? (8'h00 - len) : len;
		len_bad = (mag == 8'h00) || (mag > RSU_SR_MAX_LEN);
		top_idx = {2'h0, base} + mag - 8'h01;
		range_bad = !len_bad && (top_idx > 8'(RSU_SR_W - 1));
	end

	// one step of the bit register; bits outside the window hold
	always_comb begin
		// neighbour vectors keep every bit select inside the store
		sr_up = {sr_q[RSU_SR_W-2:0], 1'b0};
		sr_dn = {1'b0, sr_q[RSU_SR_W-1:1]};
		sr_shift = sr_q;
		sr_out = 1'b0;
		for (int i = 0; i < RSU_SR_W; i++) begin
			if (!len[7]) begin
				if (i == int'(base)) begin
					sr_shift[i] = din;
				end else if (i > int'(base) && i <= int'(top_idx)) begin
					sr_shift[i] = sr_up[i];
				end
				if (i == int'(top_idx)) begin
					sr_out = sr_q[i];
				end
			end else begin
				if (i == int'(top_idx)) begin
					sr_shift[i] = din;
				end else if (i >= int'(base) && i < int'(top_idx)) begin
					sr_shift[i] = sr_dn[i];
				end
				if (i == int'(base)) begin
					sr_out = sr_q[i];
				end
			end
		end
	end

	// operand, count and geometry registers take plain bus writes
	always_comb begin
		opnd_d = opnd_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		if (wr_en) begin
			unique case (paddr)
				RSU_OPND_OFS: opnd_d = pwdata;
				RSU_CNT_OFS: cnt_d = pwdata[7:0];
				RSU_SRCFG_OFS: cfg_d = pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// operation next state; everything but the bus loads of the store moves on the issuing edge
	always_comb begin
		res_d = res_q;
		err_d = err_q;
		msb_byte_d = msb_byte_q;
		msb_bit_d = msb_bit_q;
		sr_d = sr_q;
		zf_d = zf_q;
		of_d = of_q;
		en_out_d = en_out_q;
		// software loads the store, an issued op steps it; never both on one edge
		if (wr_en) begin
			unique case (paddr)
				RSU_SRLO_OFS: sr_d[31:0] = pwdata;
				RSU_SRHI_OFS: sr_d[63:32] = pwdata;
				default: begin
				end
			endcase
		end
		if (issue) begin
			// a failed step clears enable_out but leaves result, zero and overflow flags as they were
			if (bad_ind) begin
				en_out_d = 1'b0;
				err_d = RSU_ERR_INDIRECT;
			end else begin
				en_out_d = 1'b1;
				err_d = RSU_ERR_NONE;
				unique case (op)
					RSU_OP_BIT_SR: begin
						// the top position is reported even when the step is refused
						msb_byte_d = top_idx[7:3];
						msb_bit_d = top_idx[2:0];
						if (len_bad) begin
							en_out_d = 1'b0;
							err_d = RSU_ERR_COUNT;
						end else if (range_bad) begin
							en_out_d = 1'b0;
							err_d = RSU_ERR_RANGE;
						end else begin
							sr_d = sr_shift;
							of_d = sr_out;
						end
					end
					RSU_OP_SWAP: begin
						// a swap leaves both flags alone
						res_d = {16'h0000, opnd_q[7:0], opnd_q[15:8]};
					end
					default: begin
						res_d = rot_res;
						zf_d = rot_zero;
						if (rot_moved) begin
							of_d = rot_last;
						end
					end
				endcase
			end
		end
	end

	// read data and error answer are prepared in the setup cycle, shown in access
	always_comb begin
		pready_d = setup;
		pslverr_d = setup && !addr_mapped(paddr);
		prdata_d = 32'h00000000;
		if (setup && !pwrite) begin
			unique case (paddr)
				RSU_CTRL_OFS: prdata_d = 32'h00000000;
				RSU_OPND_OFS: prdata_d = opnd_q;
				RSU_CNT_OFS: prdata_d = {24'h000000, cnt_q};
				RSU_SRCFG_OFS: prdata_d = {16'h0000, cfg_q};
				RSU_RES_OFS: prdata_d = res_q;
				RSU_STAT_OFS: begin
					prdata_d[RSU_ST_ZF_BIT] = zf_q;
					prdata_d[RSU_ST_OF_BIT] = of_q;
					prdata_d[RSU_ST_EN_OUT_BIT] = en_out_q;
					prdata_d[RSU_ST_MSBBIT_LSB +: 3] = msb_bit_q;
					prdata_d[RSU_ST_MSBBYTE_LSB +: 5] = msb_byte_q;
					prdata_d[RSU_ST_ERR_LSB +: 16] = err_q;
				end
				RSU_SRLO_OFS: prdata_d = sr_q[31:0];
				RSU_SRHI_OFS: prdata_d = sr_q[63:32];
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// bus-written registers; reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_q <= 32'h00000000;
			cnt_q <= 8'h00;
			cfg_q <= 16'h0000;
		end else begin
			opnd_q <= opnd_d;
			cnt_q <= cnt_d;
			cfg_q <= cfg_d;
		end
	end

	// operation results, flags and the bit store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= 32'h00000000;
			err_q <= RSU_ERR_NONE;
			msb_byte_q <= 5'h00;
			msb_bit_q <= 3'h0;
			sr_q <= 64'h0000000000000000;
			zf_q <= 1'b0;
			of_q <= 1'b0;
			en_out_q <= RSU_EN_OUT_RST;
		end else begin
			res_q <= res_d;
			err_q <= err_d;
			msb_byte_q <= msb_byte_d;
			msb_bit_q <= msb_bit_d;
			sr_q <= sr_d;
			zf_q <= zf_d;
			of_q <= of_d;
			en_out_q <= en_out_d;
		end
	end

	// bus answer is registered so ready, error and read data come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign enable_out = en_out_q;
	assign zero_flag = zf_q;
	assign overflow_flag = of_q;
endmodule

// ---- rsu_props.sv ----
`timescale 1ns/1ns
module rsu_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic enable_out,
	input wire logic zero_flag,
	input wire logic overflow_flag
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// setup phase, then the accepted write of an operation
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctrl_wr;
		psel && penable && pready && pwrite && paddr == 8'h00;
	endsequence
	// any edge that does not take an operation
	sequence s_no_op;
		!(psel && penable && pready && pwrite && paddr == 8'h00);
	endsequence
	chk_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	chk_unmapped_err: assert property (s_setup and paddr > 8'h1c |=> pslverr)
		else $error("unmapped address not refused");
	// flags only move on the edge that takes an operation
	chk_outs_hold: assert property (s_no_op |=> $stable(enable_out) &&
		$stable(zero_flag) && $stable(overflow_flag))
		else $error("flags moved without an operation");
	chk_bad_ind_eno: assert property (s_ctrl_wr and pwdata[3] |=> !enable_out)
		else $error("enable kept on bad reference");
	chk_swap_flags: assert property (s_ctrl_wr and pwdata[3:0] == 4'h7 |=> enable_out &&
		$stable(zero_flag) && $stable(overflow_flag))
		else $error("swap touched flags");
	chk_rot_enable: assert property (s_ctrl_wr and pwdata[3:0] < 4'h6 |=> enable_out)
		else $error("good rotate dropped enable");
endmodule
bind rsu_top rsu_props u_rsu_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .enable_out(enable_out), .zero_flag(zero_flag),
	.overflow_flag(overflow_flag));

// ---- rsu_seq_model.sv ----
`timescale 1ns/1ns
module rsu_seq_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer per call, so each shift op advances the register one step only
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines flip so stale data is never taken as live
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	import rsu_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic enable_out, zero_flag, overflow_flag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	int fails = 0, tests_run = 0, cycles = 0;
	// op, operand, count, result, status per rotate, swap and bad-reference case
	logic [31:0] ctl [8] = '{32'h0, 32'h4, 32'h2, 32'h3, 32'h5, 32'h1, 32'h7, 32'h8};
	logic [31:0] opv [8] = '{32'h181, 32'h8001, 32'h1, 32'h100, 32'h8000_0000, 32'h1,
		32'h1234_5678, 32'h55};
	logic [31:0] cnt [8] = '{32'h1, 32'h11, 32'h20, 32'h3, 32'h1, 32'h1, 32'h0, 32'h1};
	logic [31:0] res [8] = '{32'hc0, 32'h3, 32'h1, 32'h0, 32'h1, 32'h8000, 32'h7856, 32'h7856};
	logic [31:0] st [8] = '{32'h6, 32'h6, 32'h6, 32'h5, 32'h6, 32'h6, 32'h6, 32'h0006_0002};
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	rsu_top u_rsu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enable_out(enable_out), .zero_flag(zero_flag),
		.overflow_flag(overflow_flag));
	rsu_seq_model u_rsu_seq_model (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		tests_run++;
		if ((got & m) !== (exp & m)) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_rsu_seq_model.xfer(1'b1, a, d, rd_q, err_q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		u_rsu_seq_model.xfer(1'b0, a, 32'h0, rd_q, err_q);
		chk(rd_q, exp, m);
	endtask
	// issue an op, then match status and the flag pins against it
	task automatic op(input logic [31:0] c, input logic [31:0] s, input logic [31:0] m);
		wr(RSU_CTRL_OFS, c);
		rd(RSU_STAT_OFS, s, m);
		chk({29'h0, enable_out, overflow_flag, zero_flag}, s, 32'h7);
	endtask
	// hang guard, far above the 189 cycles the sequence needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(RSU_STAT_OFS, 32'h4, 32'hffff_ffff);
		for (int i = 0; i < 8; i++) begin
			wr(RSU_OPND_OFS, opv[i]);
			wr(RSU_CNT_OFS, cnt[i]);
			op(ctl[i], st[i], 32'hffff_ffff);
			rd(RSU_RES_OFS, res[i], 32'hffff_ffff);
		end
		// shift up from bit 12, length 14: top bit lands in byte 3 bit 1
		wr(RSU_SRLO_OFS, 32'h0200_0000);
		wr(RSU_SRHI_OFS, 32'h0);
		wr(RSU_SRCFG_OFS, 32'h0e0c);
		op(32'h16, 32'h316, 32'hffff_ffff);
		rd(RSU_SRLO_OFS, 32'h1000, 32'hffff_ffff);
		wr(RSU_SRLO_OFS, 32'h1);
		wr(RSU_SRCFG_OFS, 32'hc000);
		op(32'h16, 32'h776, 32'hffff_ffff);
		rd(RSU_SRLO_OFS, 32'h0, 32'hffff_ffff);
		rd(RSU_SRHI_OFS, 32'h8000_0000, 32'hffff_ffff);
		wr(RSU_SRCFG_OFS, 32'h4100);
		op(32'h6, 32'h0092_0002, 32'hffff_0007);
		wr(RSU_SRCFG_OFS, 32'h0938);
		op(32'h6, 32'h0091_0002, 32'hffff_0007);
		rd(RSU_SRHI_OFS, 32'h8000_0000, 32'hffff_ffff);
		rd(8'h20, 32'h0, 32'hffff_ffff);
		chk({31'h0, err_q}, 32'h1, 32'h1);
		report_and_stop();
	end
endmodule
